// ---- verilog/pdpc_pkg.sv ----
// Functional notes
// - Locked: osc output high, ref output low
// - Polarity high: monitor shows divided reference
// - Polarity low: monitor shows divided oscillator
// - Monitor output serves divider test mode
// - Equal signals float main pump output
// - Strobe high: bypass pump follows main
// - Strobe low: bypass floats, main active
// - Lock indicator pulses low on mismatch
// - Lock indicator is NOR of up/down
// - Polarity inverts comparators and main pump
// - Reference lagging, polarity high: ref output pulses high
`default_nettype none
package pdpc_pkg;
    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic RST_UP      = 1'h0;
    localparam logic RST_DOWN    = 1'h0;
    localparam logic RST_LOCK    = 1'h1;
    localparam logic RST_SYNC    = 1'h0;
    // Locked-state comparator levels double as their reset values
    localparam logic RST_REF_CMP = 1'h0;
    localparam logic RST_VCO_CMP = 1'h1;
    // Pumps start floating, so the loop filter keeps its charge
    localparam logic RST_PUMP    = 1'h0;
    localparam logic RST_PUMP_OE = 1'h0;
    localparam logic RST_MON     = 1'h0;

    // Pump drive state: off means high impedance
    typedef enum logic [1:0] {
        PDPC_PUMP_OFF,
        PDPC_PUMP_SRC,
        PDPC_PUMP_SNK
    } pdpc_pump_t;
endpackage
`default_nettype wire

// ---- verilog/pdpc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ---------------------------------------------------------------------
module pdpc_sync
    import pdpc_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         clk_sys_in,
    input  wire logic         rst_b_in,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // First stage feeds only the second
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q <= {W{RST_SYNC}};
            sync_q <= {W{RST_SYNC}};
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // pdpc_sync
`default_nettype wire

// ---- verilog/pdpc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Phase/frequency detector output stage
// ---------------------------------------------------------------------
module pdpc_top
    import pdpc_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_b_in,
    // Divided signals and controls (pins)
    input  wire logic ref_divided_in,
    input  wire logic vco_divided_in,
    input  wire logic phase_polarity_select_in,
    input  wire logic load_strobe_in,
    // Comparator outputs
    output logic      ref_cmp_out,
    output logic      vco_cmp_out,
    // Main charge pump (three-state)
    output logic      main_pump_out,
    output logic      main_pump_oe_out,
    // Bypass charge pump (three-state)
    output logic      bypass_pump_out,
    output logic      bypass_pump_oe_out,
    // Monitor and lock
    output logic      monitor_out,
    output logic      lock_indicator_out
);
    // -----------------------------------------------------------------
    // Helper functions
    // -----------------------------------------------------------------
    // Rising edge of a synchronised level against its one-clock copy;
    // shared by both divided signals so they see identical latency
    function automatic logic rise_of(
        input logic now_v,
        input logic prev_v
    );
        return now_v & ~prev_v;
    endfunction

    // -----------------------------------------------------------------
    // Input synchronisation
    // -----------------------------------------------------------------
    logic [3:0] pins_s;
    logic       ref_s;
    logic       vco_s;
    logic       pol_s;
    logic       strobe_s;

    // Pins take two flops, the detector one and the outputs one more:
    // a divided-pin edge reaches the pump, comparator and lock outputs four clocks later, the monitor three. Each level of a
    // divided signal must last at least one clock to be seen at all.
    pdpc_sync #(.W(4)) u_sync (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .async_in   ({ref_divided_in, vco_divided_in,
                      phase_polarity_select_in, load_strobe_in}),
        .sync_out   (pins_s)
    );

    // Unpack synchronised pins
    assign ref_s    = pins_s[3];
    assign vco_s    = pins_s[2];
    assign pol_s    = pins_s[1];
    assign strobe_s = pins_s[0];

    // -----------------------------------------------------------------
    // Edge detection and up/down flip-flops
    // -----------------------------------------------------------------
    logic ref_dly_q;
    logic ref_dly_d;
    logic vco_dly_q;
    logic vco_dly_d;
    logic up_q;
    logic up_d;
    logic down_q;
    logic down_d;
    logic ref_rise;
    logic vco_rise;

    // Classic two-flop detector; both set means clear at once.
    // Edges closer than one clock merge, and edges in the same
    // synchronised cycle cancel, so the in-phase spike of a locked
    // loop does not appear: the pump simply stays floating.
    always_comb begin
        ref_dly_d = ref_s;
        vco_dly_d = vco_s;
        ref_rise  = rise_of(ref_s, ref_dly_q);
        vco_rise  = rise_of(vco_s, vco_dly_q);
        up_d      = up_q | ref_rise;
        down_d    = down_q | vco_rise;
        if (up_d && down_d) begin
            up_d   = 1'b0;
            down_d = 1'b0;
        end
    end

    // Delayed copies reset to the synchroniser's level, so a pin that
    // is low at release gives no false edge
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ref_dly_q <= RST_SYNC;
            vco_dly_q <= RST_SYNC;
            up_q      <= RST_UP;
            down_q    <= RST_DOWN;
        end else begin
            ref_dly_q <= ref_dly_d;
            vco_dly_q <= vco_dly_d;
            up_q      <= up_d;
            down_q    <= down_d;
        end
    end

    // -----------------------------------------------------------------
    // Comparator outputs
    // -----------------------------------------------------------------
    logic ref_cmp_q;
    logic ref_cmp_d;
    logic vco_cmp_q;
    logic vco_cmp_d;

    // Polarity high: ref output marks down request (VCO too fast),
    // osc output is low while an up request is pending
    always_comb begin
        if (pol_s) begin
            ref_cmp_d = down_q;
            vco_cmp_d = ~up_q;
        end else begin
            ref_cmp_d = up_q;
            vco_cmp_d = ~down_q;
        end
    end

    // Reset levels equal the locked levels, so no false lead shows
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ref_cmp_q <= RST_REF_CMP;
            vco_cmp_q <= RST_VCO_CMP;
        end else begin
            ref_cmp_q <= ref_cmp_d;
            vco_cmp_q <= vco_cmp_d;
        end
    end

    // -----------------------------------------------------------------
    // Main and bypass charge pumps
    // -----------------------------------------------------------------
    logic       main_q;
    logic       main_d;
    logic       main_oe_q;
    logic       main_oe_d;
    logic       byp_q;
    logic       byp_d;
    logic       byp_oe_q;
    logic       byp_oe_d;
    pdpc_pump_t pump;

    // Pump source raises the VCO when polarity high; the bypass pump
    // copies the main one and only its enable sees the strobe
    always_comb begin
        if (up_q == down_q) begin
            pump = PDPC_PUMP_OFF;
        end else if (up_q ^ ~pol_s) begin
            pump = PDPC_PUMP_SRC;
        end else begin
            pump = PDPC_PUMP_SNK;
        end
        main_d    = (pump == PDPC_PUMP_SRC);
        main_oe_d = (pump != PDPC_PUMP_OFF);
        byp_d     = main_d;
        byp_oe_d  = main_oe_d & strobe_s;
    end

    // Enables reset low: a floating pump leaves the filter untouched,
    // so a reset in mid-lock costs no frequency step
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            main_q    <= RST_PUMP;
            main_oe_q <= RST_PUMP_OE;
            byp_q     <= RST_PUMP;
            byp_oe_q  <= RST_PUMP_OE;
        end else begin
            main_q    <= main_d;
            main_oe_q <= main_oe_d;
            byp_q     <= byp_d;
            byp_oe_q  <= byp_oe_d;
        end
    end

    // -----------------------------------------------------------------
    // Monitor and lock indicator
    // -----------------------------------------------------------------
    logic mon_q;
    logic mon_d;
    logic lock_q;
    logic lock_d;

    // Monitor gives a sampled test view of the divider chain. Lock
    // pulses low while either request stands; a steady flag needs an
    // outside filter, as the pulses are as short as the phase error
    always_comb begin
        mon_d  = pol_s ? ref_s : vco_s;
        lock_d = ~(up_q | down_q);
    end

    // Lock resets high: nothing is pending after reset
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mon_q  <= RST_MON;
            lock_q <= RST_LOCK;
        end else begin
            mon_q  <= mon_d;
            lock_q <= lock_d;
        end
    end

    // -----------------------------------------------------------------
    // Output ports
    // -----------------------------------------------------------------
    // Ports come straight from the output flops, free of glitches
    assign ref_cmp_out        = ref_cmp_q;
    assign vco_cmp_out        = vco_cmp_q;
    assign main_pump_out      = main_q;
    assign main_pump_oe_out   = main_oe_q;
    assign bypass_pump_out    = byp_q;
    assign bypass_pump_oe_out = byp_oe_q;
    assign monitor_out        = mon_q;
    assign lock_indicator_out = lock_q;
endmodule // pdpc_top
`default_nettype wire

// ---- test/pdpc_checker_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Port relations of the detector
// ----
module pdpc_checker (
    input wire logic clk_sys_in, rst_b_in, ref_divided_in, vco_divided_in,
    input wire logic phase_polarity_select_in, load_strobe_in, ref_cmp_out,
    input wire logic vco_cmp_out, main_pump_out, main_pump_oe_out,
    input wire logic bypass_pump_out, bypass_pump_oe_out, monitor_out,
    input wire logic lock_indicator_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    // Pump, lock and monitor; lead windows allow the sync latency
    lock_nor_a: assert property (
        lock_indicator_out == !main_pump_oe_out) else $error("lock");
    bypass_follow_a: assert property (
        bypass_pump_oe_out |-> main_pump_oe_out
        && bypass_pump_out == main_pump_out) else $error("bypass");
    bypass_float_a: assert property (
        !load_strobe_in [*4] |=> !bypass_pump_oe_out) else $error("float");
    monitor_ref_a: assert property (
        (phase_polarity_select_in && $stable(ref_divided_in)) [*5]
        |-> monitor_out == ref_divided_in) else $error("monitor");
    locked_quiet_a: assert property (
        !main_pump_oe_out |-> !ref_cmp_out && vco_cmp_out) else $error("idle");
    ref_lead_a: assert property (
        $rose(ref_divided_in) && !vco_divided_in && !main_pump_oe_out
        |-> ##[3:5] (main_pump_oe_out
        && main_pump_out == phase_polarity_select_in
        && ref_cmp_out != phase_polarity_select_in
        && vco_cmp_out != phase_polarity_select_in)) else $error("up");
    vco_lead_a: assert property (
        $rose(vco_divided_in) && !ref_divided_in && !main_pump_oe_out
        |-> ##[3:5] (main_pump_oe_out
        && main_pump_out != phase_polarity_select_in
        && ref_cmp_out == phase_polarity_select_in
        && vco_cmp_out == phase_polarity_select_in)) else $error("down");
    equal_float_a: assert property (
        $rose(ref_divided_in) && $rose(vco_divided_in) && !main_pump_oe_out
        |=> !main_pump_oe_out [*6]) else $error("equal");
endmodule // pdpc_checker
bind pdpc_top pdpc_checker u_chk (.*);
`default_nettype wire

// ---- test/pdpc_pump_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Loop filter charge, floating pumps add nothing
// ----
module pdpc_pump_model (
    input wire logic clk_sys_in, main_pump_out, main_pump_oe_out,
    output var int   charge_out
);
    // Source adds a unit, sink removes one
    initial charge_out = 0;
    always @(posedge clk_sys_in) begin
        if (main_pump_oe_out) begin
            charge_out <= charge_out + (main_pump_out ? 1 : -1);
        end
    end
endmodule // pdpc_pump_model
`default_nettype wire

// ---- test/pdpc_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Random lead, lag and equal edges at both polarities
// ----
module pdpc_tb_top;
    logic clk_sys_in, rst_b_in, ref_divided_in, vco_divided_in, up, dn;
    logic phase_polarity_select_in, load_strobe_in, ref_cmp_out, vco_cmp_out;
    logic main_pump_out, main_pump_oe_out, bypass_pump_out, bypass_pump_oe_out;
    logic monitor_out, lock_indicator_out;
    logic [31:0] seed;
    int fails, comparisons, charge_out, c0;
    pdpc_top dut (.*);
    pdpc_pump_model u_pump (.*);
    // Clock
    initial begin
        clk_sys_in = 1'h0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask
    // Outputs follow the model's request bits, polarity, strobe and divided pins once settled
    task automatic check_all;
        logic p;
        logic a;
        p = phase_polarity_select_in;
        a = up | dn;
        chk("lock", !a, lock_indicator_out);
        chk("vco_cmp", p ? !up : !dn, vco_cmp_out);
        chk("ref_cmp", p ? dn : up, ref_cmp_out);
        chk("main_oe", a, main_pump_oe_out);
        chk("byp_oe", a & load_strobe_in, bypass_pump_oe_out);
        chk("monitor", p ? ref_divided_in : vco_divided_in,
            monitor_out);
        if (a) chk("main", p ? up : dn, main_pump_out);
        if (a) chk("bypass", p ? up : dn, bypass_pump_out);
    endtask
    task automatic settle;
        repeat (6) @(negedge clk_sys_in);
    endtask
    task automatic end_of_test;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Each round: idle, first edge (or both), then second edge
    initial begin
        seed = 32'hE474;
        rst_b_in = 1'h0;
        {ref_divided_in, vco_divided_in, up, dn} = 4'h0;
        {phase_polarity_select_in, load_strobe_in} = 2'h3;
        repeat (2) @(negedge clk_sys_in);
        rst_b_in = 1'h1;
        repeat (40) begin
            seed = xs(seed);
            {ref_divided_in, vco_divided_in, up, dn} = 4'h0;
            {phase_polarity_select_in, load_strobe_in} = seed[1:0];
            settle;
            check_all;
            {ref_divided_in, vco_divided_in, up, dn} = seed[3] ? 4'hC
                : {!seed[2], seed[2], !seed[2], seed[2]};
            c0 = charge_out;
            settle;
            check_all;
            if (seed[3]) chk("charge", 1'h1, charge_out == c0);
            else begin
                chk("charge_dir", phase_polarity_select_in ? up : dn,
                    charge_out > c0);
                chk("charge_moved", 1'h1, charge_out != c0);
            end
            {ref_divided_in, vco_divided_in, up, dn} = 4'hC;
            settle;
            check_all;
        end
        end_of_test;
    end
    // Watchdog
    initial begin
        repeat (3000) @(posedge clk_sys_in);
        fails++;
        end_of_test;
    end
endmodule // pdpc_tb_top
`default_nettype wire
